// ### pmlm_accum.sv
// Rectifying accumulator with sample counter for the level meter
module pmlm_accum #(
  parameter int unsigned SAMPLE_W = 16,                 // Linear sample width
  parameter int unsigned ACC_W    = 24,                 // Accumulator width
  parameter int unsigned SHIFT    = 8                   // Scale before the result
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  clear,             // Restart the interval
  input  wire logic                  sample_en,         // One new sample
  input  wire logic [SAMPLE_W-1:0]   sample,            // Two's complement
  input  wire logic [7:0]            target,            // Samples per interval
  output logic                       done,              // Interval complete pulse
  output logic [pmlm_pkg::RES_W-1:0] sum                // Scaled, saturated sum
);
  logic [ACC_W-1:0]    acc_r;                           // Running sum
  logic [ACC_W-1:0]    acc_nxt;                         // Sum including this sample
  logic [7:0]          cnt_r;                           // Samples taken so far
  logic [7:0]          cnt_nxt;                         // Count including this sample
  logic [SAMPLE_W-1:0] mag;                             // Rectified sample
  logic [ACC_W-1:0]    scaled;                          // Sum after scaling
  logic                last;                            // This sample ends the interval

  // Magnitude; the most negative code maps to its true size, fits unsigned
  assign mag     = sample[SAMPLE_W-1] ? SAMPLE_W'(-sample) : sample;
  assign acc_nxt = acc_r + ACC_W'(mag);
  assign cnt_nxt = cnt_r + 8'h01;
  // A target of zero behaves as one, so the meter never stalls
  assign last    = (cnt_nxt >= target);
  assign scaled  = acc_nxt >> SHIFT;

  // Accumulate and count; clear and restart right after each interval
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= '0;
      cnt_r <= 8'h00;
    end else if (clear) begin
      // Discard partial sums from an old channel or mode
      acc_r <= '0;
      cnt_r <= 8'h00;
    end else if (sample_en && last) begin
      acc_r <= '0;                                      // [R12]
      cnt_r <= 8'h00;                                   // [R12]
    end else if (sample_en) begin
      acc_r <= acc_nxt;                                 // [R4]
      cnt_r <= cnt_nxt;                                 // [R3]
    end
  end

  // Completion pulse and saturated result, both taken in one edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
      sum  <= '0;
    end else begin
      done <= sample_en && last && !clear;              // [R4]
      if (sample_en && last && !clear) begin
        // Saturate rather than wrap: a clipped level is still a loud one
        if (|(scaled >> pmlm_pkg::RES_W)) begin
          sum <= '1;
        end else begin
          sum <= scaled[pmlm_pkg::RES_W-1:0];
        end
      end
    end
  end
endmodule

// ### pmlm_meter.sv
// Level meter shared by eight PCM channels, with its global command registers
// What this block does
// [R1] One meter; three-bit field picks the channel
// [R2] Meter measures only while its on bit is 1
// [R3] Count register sets samples per measurement interval
// [R4] Sum magnitudes, then set ready and latch both
// [R5] Low: 7 result bits plus ready; high: upper 8
// [R6] Reading the high result clears ready
// [R7] New result overwrites unread result, sets ready again
// [R8] Software should read low before high
// [R9] Linear mode delivers accumulated sum to result registers
// [R10] Compressed mode copies PCM word into high register
// [R11] Global commands: address low five bits, bit7 writes
// [R12] After latching, restart accumulation at once
// [R13] Channel or mode change restarts the accumulation
module pmlm_meter #(
  parameter int unsigned NCH    = 8,                    // Voice channels sharing the meter
  parameter int unsigned LIN_W  = 16,                   // Linear PCM width
  parameter int unsigned COMP_W = 8,                    // Compressed PCM width
  parameter int unsigned ACC_W  = 24,                   // Accumulator width
  parameter int unsigned SHIFT  = 8                     // Accumulator to result scaling
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    frame_tick,      // One pulse per 8 kHz frame
  input  wire logic [NCH*LIN_W-1:0]    pcm_linear,      // Linear samples, channel 0 lowest
  input  wire logic [NCH*COMP_W-1:0]   pcm_comp,        // Compressed samples, channel 0 lowest
  input  wire logic                    cmd_valid,       // Command from serial_control_port
  input  wire logic [7:0]              cmd_byte,        // Command byte
  input  wire logic [7:0]              cmd_wdata,       // Data byte for writes
  output logic                         rd_valid,        // Read answer pulse
  output logic [7:0]                   rd_data,         // Read answer byte
  output logic                         meter_irq_ready  // Copy of result_ready_flag
);
  localparam int unsigned SEL_W = pmlm_pkg::CFG_CS_W;

  logic [7:0]             config_r;                     // Channel, mode and on bit
  logic [7:0]             count_r;                      // Samples per interval
  logic [7:0]             res_high_r;                   // meter_result_high
  logic [pmlm_pkg::RES_LOW_W-1:0] res_low_r;            // Low result bits
  logic                   ready_r;                      // result_ready_flag
  logic [SEL_W-1:0]       sel_q;                        // Channel seen last cycle
  logic                   lin_q;                        // Mode seen last cycle
  logic                   on_q;                         // On bit seen last cycle

  logic                   is_global;                    // Command type is global
  logic                   is_write;                     // Command writes
  logic [4:0]             addr;                         // Register address
  logic                   wr_cfg;                       // Write to config
  logic                   wr_cnt;                       // Write to count
  logic                   rd_hit;                       // Read of a meter register
  logic                   rd_high;                      // Read of the high result
  logic [SEL_W-1:0]       sel;                          // Chosen channel
  logic                   lin;                          // Linear mode
  logic                   on;                           // Meter enabled
  logic                   restart;                      // Drop the running interval
  logic [LIN_W-1:0]       lin_sample;                   // Chosen linear sample
  logic [COMP_W-1:0]      comp_sample;                  // Chosen compressed sample
  logic                   acc_done;                     // Interval finished
  logic [pmlm_pkg::RES_W-1:0] acc_sum;                  // Finished sum
  logic                   take_sum;                     // Latch a linear result

  // Command decode
  assign addr      = cmd_byte[pmlm_pkg::CMD_ADDR_HI:0];                       // [R11]
  assign is_global = (cmd_byte[pmlm_pkg::CMD_TYPE_HI:pmlm_pkg::CMD_TYPE_LO]
                      == pmlm_pkg::CMD_GLOBAL);                               // [R11]
  assign is_write  = cmd_byte[pmlm_pkg::CMD_RW_BIT];                          // [R11]
  assign wr_cfg    = cmd_valid && is_global && is_write && (addr == pmlm_pkg::ADDR_CONFIG);
  assign wr_cnt    = cmd_valid && is_global && is_write && (addr == pmlm_pkg::ADDR_COUNT);
  assign rd_hit    = cmd_valid && is_global && !is_write &&
                     ((addr == pmlm_pkg::ADDR_RES_LOW) || (addr == pmlm_pkg::ADDR_RES_HIGH) ||
                      (addr == pmlm_pkg::ADDR_COUNT)   || (addr == pmlm_pkg::ADDR_CONFIG));
  assign rd_high   = rd_hit && (addr == pmlm_pkg::ADDR_RES_HIGH);

  // Config fields
  assign sel = config_r[pmlm_pkg::CFG_CS_HI -: SEL_W];                        // [R1]
  assign lin = config_r[pmlm_pkg::CFG_LIN_BIT];
  assign on  = config_r[pmlm_pkg::CFG_ON_BIT];                                // [R2]

  // Channel mux; the select stays inside the packed sample bus
  assign lin_sample  = pcm_linear[sel*LIN_W +: LIN_W];                        // [R1]
  assign comp_sample = pcm_comp[sel*COMP_W +: COMP_W];                        // [R1]

  // Restart when off, in compressed mode, or when channel or mode just moved
  assign restart  = !on || !lin || (sel != sel_q) || (lin != lin_q) || !on_q; // [R13]
  // A result finished under an old setting is never reported
  assign take_sum = acc_done && on && lin && !restart;                        // [R9]

  // Accumulator and sample counter
  pmlm_accum #(
    .SAMPLE_W (LIN_W),
    .ACC_W    (ACC_W),
    .SHIFT    (SHIFT)
  ) u_accum (
    .clk       (clk),
    .arst_n    (arst_n),
    .clear     (restart),
    .sample_en (frame_tick && on && lin),
    .sample    (lin_sample),
    .target    (count_r),
    .done      (acc_done),
    .sum       (acc_sum)
  );

  // Writable configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      config_r <= pmlm_pkg::RST_CONFIG;
      count_r  <= pmlm_pkg::RST_COUNT;
    end else begin
      if (wr_cfg) begin
        // Only meter fields are kept; other bits read back as zero
        config_r <= cmd_wdata & {1'b1, 1'b1, 3'h0, {SEL_W{1'b1}}};
      end
      if (wr_cnt) begin
        count_r <= cmd_wdata;                           // [R3]
      end
    end
  end

  // Previous settings, used to spot a change of channel or mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q <= '0;
      lin_q <= 1'b0;
      on_q  <= 1'b0;
    end else begin
      sel_q <= sel;
      lin_q <= lin;
      on_q  <= on;
    end
  end

  // Result registers; a new result simply overwrites an unread one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res_high_r <= pmlm_pkg::RST_RESULT;
      res_low_r  <= '0;
    end else if (take_sum) begin
      res_low_r  <= acc_sum[pmlm_pkg::RES_LOW_W-1:0];                        // [R5]
      res_high_r <= acc_sum[pmlm_pkg::RES_W-1:pmlm_pkg::RES_LOW_W];          // [R5]
    end else if (on && !lin && frame_tick) begin
      // Compressed word passes straight through, untouched
      res_high_r <= comp_sample;                                             // [R10]
    end
  end

  // Ready flag; a completion in the clearing cycle wins over the read
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_r <= 1'b0;
    end else if (take_sum) begin
      ready_r <= 1'b1;                                  // [R7]
    end else if (rd_high) begin
      // Why low first matters: this read wipes the flag
      ready_r <= 1'b0;                                  // [R6] [R8]
    end
  end

  // Read answers, one cycle after the command
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= pmlm_pkg::ZERO_BYTE;
    end else begin
      rd_valid <= rd_hit;                               // [R11]
      if (rd_hit) begin
        case (addr)
          pmlm_pkg::ADDR_RES_LOW:  rd_data <= {ready_r, res_low_r};   // [R5]
          pmlm_pkg::ADDR_RES_HIGH: rd_data <= res_high_r;             // [R5]
          pmlm_pkg::ADDR_COUNT:    rd_data <= count_r;
          pmlm_pkg::ADDR_CONFIG:   rd_data <= config_r;
          default:                 rd_data <= pmlm_pkg::ZERO_BYTE;
        endcase
      end
    end
  end

  // Flag mirror for a status pin, registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meter_irq_ready <= 1'b0;
    end else begin
      meter_irq_ready <= ready_r || take_sum;
    end
  end

  // Checks
  sequence s_linear_done;
    acc_done && on && lin && !restart;
  endsequence

  sequence s_high_read_alone;
    rd_high && !take_sum;
  endsequence

  a_ready_on_done: assert property (  // [R4]
    @(posedge clk) disable iff (!arst_n)
    s_linear_done |=> ready_r)
    else $error("ready not set after a finished interval");

  a_latch_both_parts: assert property (  // [R5]
    @(posedge clk) disable iff (!arst_n)
    s_linear_done |=> ({res_high_r, res_low_r} == $past(acc_sum)))
    else $error("result registers do not hold the finished sum");

  a_high_read_clear: assert property (  // [R6]
    @(posedge clk) disable iff (!arst_n)
    s_high_read_alone |=> !ready_r)
    else $error("high result read left ready set");

  a_set_beats_clear: assert property (  // [R7]
    @(posedge clk) disable iff (!arst_n)
    (rd_high && take_sum) |=> ready_r)
    else $error("completion lost against a high read");

  a_off_no_ready: assert property (  // [R2]
    @(posedge clk) disable iff (!arst_n)
    (!on && !ready_r && !rd_high) |=> !ready_r)
    else $error("ready rose while meter was off");

  a_comp_copy: assert property (  // [R10]
    @(posedge clk) disable iff (!arst_n)
    (on && !lin && frame_tick) |=> (res_high_r == $past(comp_sample)))
    else $error("compressed word not copied to high result");

  a_change_restart: assert property (  // [R13]
    @(posedge clk) disable iff (!arst_n)
    ($changed(sel) || $changed(lin)) |-> restart ##1 !acc_done)
    else $error("accumulation not restarted on setting change");

  a_read_answer: assert property (  // [R11]
    @(posedge clk) disable iff (!arst_n)
    rd_hit |=> rd_valid ##1 (!rd_valid || $past(rd_hit)))
    else $error("read answer missing or stretched");

  a_done_on_sample: assert property (  // [R3]
    @(posedge clk) disable iff (!arst_n)
    acc_done |-> $past(frame_tick && on && lin))
    else $error("interval ended without a sample");

  a_chan_select: assert property (  // [R1]
    @(posedge clk) disable iff (!arst_n)
    wr_cfg |=> (sel == $past(cmd_wdata[pmlm_pkg::CFG_CS_HI -: SEL_W])))
    else $error("channel field not taken from the config write");

  // Register write path, checked apart from the accumulator
  a_cfg_write: assert property (  // [R2]
    @(posedge clk) disable iff (!arst_n)
    wr_cfg |=> ((on == $past(cmd_wdata[pmlm_pkg::CFG_ON_BIT])) &&
                (lin == $past(cmd_wdata[pmlm_pkg::CFG_LIN_BIT]))))
    else $error("on or mode bit not taken from the config write");

  a_count_write: assert property (  // [R3]
    @(posedge clk) disable iff (!arst_n)
    wr_cnt |=> (count_r == $past(cmd_wdata)))
    else $error("sample count not taken from the write");

  // Switching off must end any interval before it can finish
  a_off_no_done: assert property (  // [R2]
    @(posedge clk) disable iff (!arst_n)
    !on |=> !acc_done)
    else $error("interval finished while meter was off");

  a_next_interval: assert property (  // [R12]
    @(posedge clk) disable iff (!arst_n)
    acc_done |-> (u_accum.cnt_r == '0))
    else $error("sample counter not restarted after a result");

  // Status pin follows the flag
  a_pin_rises: assert property (  // [R4]
    @(posedge clk) disable iff (!arst_n)
    s_linear_done |=> meter_irq_ready)
    else $error("ready pin not raised with the result");

  a_pin_falls: assert property (  // [R6]
    @(posedge clk) disable iff (!arst_n)
    (!ready_r && !take_sum) |=> !meter_irq_ready)
    else $error("ready pin high without the flag");

  // Results only move on a finished interval or a compressed copy
  a_result_hold: assert property (  // [R7]
    @(posedge clk) disable iff (!arst_n)
    (!take_sum && !(on && !lin && frame_tick)) |=>
      ($stable(res_high_r) && $stable(res_low_r)))
    else $error("result registers changed without a new result");

  a_comp_low_kept: assert property (  // [R10]
    @(posedge clk) disable iff (!arst_n)
    (on && !lin) |=> $stable(res_low_r))
    else $error("compressed mode touched the low result");

  a_comp_no_ready: assert property (  // [R10]
    @(posedge clk) disable iff (!arst_n)
    (on && !lin && !ready_r) |=> !ready_r)
    else $error("compressed mode raised ready");

  a_foreign_quiet: assert property (  // [R11]
    @(posedge clk) disable iff (!arst_n)
    (cmd_valid && !is_global) |=> !rd_valid)
    else $error("non-global command answered");

  a_low_read_data: assert property (  // [R5]
    @(posedge clk) disable iff (!arst_n)
    (rd_hit && (addr == pmlm_pkg::ADDR_RES_LOW)) |=>
      (rd_data == {$past(ready_r), $past(res_low_r)}))
    else $error("low result read returned wrong byte");

  a_high_read_data: assert property (  // [R5]
    @(posedge clk) disable iff (!arst_n)
    (rd_hit && (addr == pmlm_pkg::ADDR_RES_HIGH)) |=> (rd_data == $past(res_high_r)))
    else $error("high result read returned wrong byte");
endmodule

// ### pmlm_meter_tb.sv
// Self-checking bench for the PCM level meter
module pmlm_meter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk;             // 250 MHz clock
  logic         arst_n;          // Async reset, active low
  logic         frame_tick;      // Frame strobe
  logic [127:0] pcm_linear;      // Eight linear samples
  logic [63:0]  pcm_comp;        // Eight compressed words
  logic         cmd_valid;       // Command strobe
  logic [7:0]   cmd_byte;        // Command byte
  logic [7:0]   cmd_wdata;       // Write data
  logic         rd_valid;        // Read answer strobe
  logic [7:0]   rd_data;         // Read answer byte
  logic         meter_irq_ready; // Ready mirror pin
  int           errors;          // Mismatches
  int           checks;          // Comparisons
  int           seed;            // Fixed random seed
  int           cycles;          // Hang guard
  int           acc;             // Bench sum of magnitudes
  int           n;               // Samples per interval
  logic         rv;              // Captured answer strobe
  logic [7:0]   rdat;            // Captured answer byte
  logic [14:0]  res;             // Expected result
  logic [7:0]   cw;              // Expected compressed word

  pmlm_meter dut_u (
    .clk             (clk),
    .arst_n          (arst_n),
    .frame_tick      (frame_tick),
    .pcm_linear      (pcm_linear),
    .pcm_comp        (pcm_comp),
    .cmd_valid       (cmd_valid),
    .cmd_byte        (cmd_byte),
    .cmd_wdata       (cmd_wdata),
    .rd_valid        (rd_valid),
    .rd_data         (rd_data),
    .meter_irq_ready (meter_irq_ready)
  );

  // Free running clock
  always #2 clk = ~clk;

  // Hang guard: whole run needs a few hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end

  // Scaled, saturated level the meter should report
  function automatic logic [14:0] level(input int a);
    return ((a >> 8) > 32'h7FFF) ? 15'h7FFF : 15'(a >> 8);
  endfunction

  // One comparison, reported at once on mismatch
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One command pulse; the answer is taken one cycle later
  task automatic cmd(input logic [7:0] b, input logic [7:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_byte  = b;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    rv        = rd_valid;
    rdat      = rd_data;
  endtask

  // Global write, never answered
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cmd({3'h5, a}, d);
    chk({7'h00, rv}, 8'h00);
  endtask

  // Global read with expected byte
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    cmd({3'h1, a}, 8'h00);
    chk({7'h00, rv}, 8'h01);
    chk(rdat, exp);
  endtask

  // One frame with fresh samples on all channels: random, or linear 0x8000 when worst
  task automatic tick(input int ch, input logic worst);
    int v;
    @(negedge clk);
    for (int k = 0; k < 8; k++) begin
      pcm_linear[k*16+:16] = worst ? 16'h8000 : 16'($random(seed));
      pcm_comp[k*8+:8]     = 8'($random(seed));
    end
    frame_tick = 1'b1;
    v          = $signed(pcm_linear[ch*16+:16]);
    acc        += (v < 0) ? -v : v;
    @(negedge clk);
    frame_tick = 1'b0;
  endtask

  // Full interval; the last frame is taken at the edge before this task looks,
  // and ready shows one edge after that
  task automatic measure(input int ch, input int cnt, input logic worst, input logic fresh);
    for (int i = 0; i < ((cnt == 0) ? 1 : cnt); i++) tick(ch, worst);
    if (fresh) chk({7'h00, meter_irq_ready}, 8'h00);
    @(negedge clk);
    chk({7'h00, meter_irq_ready}, 8'h01);
    res = level(acc);
  endtask

  // Low first so ready is seen before the high read clears it
  task automatic readout();
    rd(pmlm_pkg::ADDR_RES_LOW, {1'b1, res[6:0]});
    rd(pmlm_pkg::ADDR_RES_HIGH, res[14:7]);
    rd(pmlm_pkg::ADDR_RES_LOW, {1'b0, res[6:0]});
    chk({7'h00, meter_irq_ready}, 8'h00);
  endtask

  // Config write, then let the restart window pass
  task automatic cfg(input logic [7:0] d);
    wr(pmlm_pkg::ADDR_CONFIG, d);
    repeat (3) @(negedge clk);
    acc = 0;
  endtask

  // Counts, verdict and stop
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence
  initial begin
    clk        = 1'b0;
    arst_n     = 1'b0;
    frame_tick = 1'b0;
    pcm_linear = '0;
    pcm_comp   = '0;
    cmd_valid  = 1'b0;
    cmd_byte   = 8'h00;
    cmd_wdata  = 8'h00;
    errors     = 0;
    checks     = 0;
    cycles     = 0;
    seed       = 32'hF7715C1E;
    acc        = 0;
    res        = 15'h0000;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    // Reset values and config readback with unused bits zero
    rd(pmlm_pkg::ADDR_RES_LOW, 8'h00);
    rd(pmlm_pkg::ADDR_RES_HIGH, 8'h00);
    rd(pmlm_pkg::ADDR_COUNT, 8'h00);
    rd(pmlm_pkg::ADDR_CONFIG, 8'h00);
    wr(pmlm_pkg::ADDR_CONFIG, 8'hFF);
    rd(pmlm_pkg::ADDR_CONFIG, 8'hC7);
    $display("test registers finished");
    // Linear metering on every channel, random interval length
    for (int ch = 0; ch < 8; ch++) begin
      n = 1 + ($unsigned($random(seed)) % 4);
      wr(pmlm_pkg::ADDR_COUNT, 8'(n));
      rd(pmlm_pkg::ADDR_COUNT, 8'(n));
      cfg(8'hC0 | 8'(ch));
      measure(ch, n, 1'b0, 1'b1);
      readout();
    end
    // Count zero acts as one sample, largest magnitude: 32768 >> 8 = 0x80
    wr(pmlm_pkg::ADDR_COUNT, 8'h00);
    cfg(8'hC5);
    measure(5, 0, 1'b1, 1'b1);
    rd(pmlm_pkg::ADDR_RES_LOW, 8'h80);
    readout();
    $display("test linear finished");
    // Unread result overwritten; next interval starts at once
    wr(pmlm_pkg::ADDR_COUNT, 8'h02);
    cfg(8'hC3);
    measure(3, 2, 1'b0, 1'b1);
    acc = 0;
    measure(3, 2, 1'b0, 1'b0);
    readout();
    $display("test overwrite finished");
    // Channel change mid interval discards the partial sum
    wr(pmlm_pkg::ADDR_COUNT, 8'h03);
    cfg(8'hC1);
    tick(1, 1'b0);
    tick(1, 1'b0);
    cfg(8'hC4);
    measure(4, 3, 1'b0, 1'b1);
    readout();
    $display("test restart finished");
    // Meter off: frames are ignored
    cfg(8'h43);
    for (int i = 0; i < 4; i++) tick(3, 1'b0);
    repeat (2) @(negedge clk);
    chk({7'h00, meter_irq_ready}, 8'h00);
    rd(pmlm_pkg::ADDR_RES_LOW, {1'b0, res[6:0]});
    // Refused commands leave state alone; every command type is tried
    wr(pmlm_pkg::ADDR_RES_LOW, 8'h55);
    rd(pmlm_pkg::ADDR_RES_HIGH, res[14:7]);
    cmd(8'h10, 8'h00);
    chk({7'h00, rv}, 8'h00);
    cmd(8'h25, 8'h00);
    chk({7'h00, rv}, 8'h00);
    cmd(8'h53, 8'h00);
    chk({7'h00, rv}, 8'h00);
    cmd(8'h93, 8'hC0);
    cmd(8'hF3, 8'h00);
    rd(pmlm_pkg::ADDR_CONFIG, 8'h43);
    $display("test refusals finished");
    // Compressed mode copies the word to the high result only
    for (int ch = 0; ch < 8; ch += 3) begin
      cfg(8'h80 | 8'(ch));
      tick(ch, 1'b0);
      cw = pcm_comp[ch*8+:8];
      @(negedge clk);
      chk({7'h00, meter_irq_ready}, 8'h00);
      rd(pmlm_pkg::ADDR_RES_HIGH, cw);
    end
    $display("test compressed finished");
    // High read lands in the very cycle a result is latched: set wins
    wr(pmlm_pkg::ADDR_COUNT, 8'h01);
    cfg(8'hC2);
    tick(2, 1'b0);
    cmd_valid = 1'b1;
    cmd_byte  = {3'h1, pmlm_pkg::ADDR_RES_HIGH};
    cmd_wdata = 8'h00;
    @(negedge clk);
    cmd_valid = 1'b0;
    chk({7'h00, rd_valid}, 8'h01);
    chk(rd_data, cw);
    res = level(acc);
    chk({7'h00, meter_irq_ready}, 8'h01);
    readout();
    $display("test set beats clear finished");
    end_of_test();
  end
endmodule

// ### pmlm_pkg.sv
// Shared constants for the PCM level meter
package pmlm_pkg;
  // Command byte layout
  localparam int unsigned CMD_RW_BIT   = 7;             // 1 = write, 0 = read
  localparam int unsigned CMD_TYPE_HI  = 6;             // Command type field top
  localparam int unsigned CMD_TYPE_LO  = 5;             // Command type field bottom
  localparam int unsigned CMD_ADDR_HI  = 4;             // Register address top
  localparam logic [1:0]  CMD_GLOBAL   = 2'h1;          // Global command type

  // Global register addresses of the meter
  localparam logic [4:0]  ADDR_RES_LOW  = 5'h10;        // meter_result_low
  localparam logic [4:0]  ADDR_RES_HIGH = 5'h11;        // meter_result_high
  localparam logic [4:0]  ADDR_COUNT    = 5'h12;        // Sample count
  localparam logic [4:0]  ADDR_CONFIG   = 5'h13;        // Channel, mode, on bit

  // Config register fields
  localparam int unsigned CFG_ON_BIT  = 7;              // meter_on_bit
  localparam int unsigned CFG_LIN_BIT = 6;              // 1 = linear, 0 = compressed
  localparam int unsigned CFG_CS_HI   = 2;              // Channel select top
  localparam int unsigned CFG_CS_W    = 3;              // Channel select width

  // Result low register fields
  localparam int unsigned RES_RDY_BIT = 7;              // result_ready_flag
  localparam int unsigned RES_LOW_W   = 7;              // Low part of result
  localparam int unsigned RES_W       = 15;             // Whole result width

  // Reset values
  localparam logic [7:0]  RST_CONFIG  = 8'h00;
  localparam logic [7:0]  RST_COUNT   = 8'h00;
  localparam logic [7:0]  RST_RESULT  = 8'h00;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
endpackage
